// ==== logic/tovd_decode.sv ====
// three-operand vector instruction decoder with wishbone status port
//
// Summary of operation
// - two dwords: opcode first, sources second
// - destination vector index from bits 7:0
// - absolute mask bits 10:8, per source
// - half select bits 14:11, sources and destination
// - clamp bit 15 passed to execution
// - opcode from bits 25:16
// - accept only encoding 110101 in 31:26
// - first source selector from bits 40:32
// - codes 0-105 are scalar registers
// - condition, trap, null, misc, mask, scc codes
// - integer constants 0, 1..64, -1..-16
// - float constants at codes 240-248
// - codes 235-238 select aperture values
// - literal or permute codes fetch trailing dword
// - codes 209-232, 239, 254 are reserved
// - codes 256-511 are vector registers
// - second, third selectors, same code map
// - output scale: none, x2, x4, half
// - negate mask bits 63:61, per source
// - opcodes 0-255 compares, upper half updates mask
// - opcodes 384-491 single source operations
// - promoted two-source and native operation ranges
// - compare result goes to scalar destination
// - compare opcode is family base plus offset
// - listed opcodes use scalar-destination layout
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`include "tovd_params.svh"
module tovd_decode (
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // instruction dword stream
   input  wire logic                dw_valid_i,
   input  wire logic [31:0]         dw_data_i,
   output logic                     dw_ready_o,
   // decoded instruction
   output logic                     inst_valid_o,
   output tovd_pkg::tovd_inst_t     inst_o,
   // wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o
);
   import tovd_pkg::*;

   tovd_state_t  st;
   logic [31:0]  dw0;
   tovd_inst_t   next_inst;
   logic         next_need;
   tovd_src_t [2:0] src_dec;
   logic         take;
   logic         ctrl_en;
   logic         illegal_seen;
   logic         foreign_seen;
   logic [15:0]  inst_cnt;
   logic         wb_req;
   logic         wb_wr;
   logic         flush;
   logic         enc_ok;
   logic [9:0]   dw_op;
   logic [7:0]   dw_dest;

   assign take    = dw_valid_i & dw_ready_o;
   assign enc_ok  = dw_data_i[`TOVD_ENC_MSB:`TOVD_ENC_LSB] == `TOVD_ENC;
   assign dw_op   = dw_data_i[`TOVD_OP_MSB:`TOVD_OP_LSB];
   assign dw_dest = dw_data_i[`TOVD_DEST_MSB:0];
   assign wb_req  = wb_cyc_i & wb_stb_i;
   assign wb_wr   = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign flush   = wb_wr & (wb_adr_i == `TOVD_CTRL_ADR) & wb_dat_i[1];

   // one source selector through the common code map
   function automatic tovd_src_t dec_src(input logic [8:0] s);
      tovd_src_t r;
      r       = '0;
      r.sel   = s;
      r.kind  = k_rsvd;
      if (s[8]) begin
         r.kind  = k_vector_gp_register;
         r.index = s[7:0];
      end else if (s <= 9'h069) begin
         r.kind  = k_scalar_gp_register;
         r.index = s[7:0];
      end else if (s >= 9'h06c && s <= 9'h07b) begin
         r.kind  = k_trap;
         r.index = s[7:0] - 8'h6c;
      end else if (s >= 9'h080 && s <= 9'h0c0) begin
         r.kind  = k_int;
         r.value = 32'(s[7:0]) - 32'h80;
      end else if (s >= 9'h0c1 && s <= 9'h0d0) begin
         r.kind  = k_int;
         r.value = 32'hc0 - 32'(s[7:0]);
      end else if (s >= 9'h0eb && s <= 9'h0ee) begin
         r.kind  = k_aper;
         r.index = s[7:0] - 8'heb;
      end else begin
         // remaining special codes, including those that need the trailing dword
         // holes of the map stay reserved
         case (s[7:0])
            8'h6a: r.kind = k_vcclo;
            8'h6b: r.kind = k_vcchi;
            8'h7c: r.kind = k_null;
            8'h7d: r.kind = k_misc0;
            8'h7e: r.kind = k_execlo;
            8'h7f: r.kind = k_exechi;
            8'hfd: r.kind = k_scc;
            8'he9: r.kind = k_perm8;
            8'hea: r.kind = k_perm8f;
            8'hfa: r.kind = k_perm16;
            8'hff: r.kind = k_lit;
            8'hf0: begin r.kind = k_flt; r.value = 32'h3f000000; end
            8'hf1: begin r.kind = k_flt; r.value = 32'hbf000000; end
            8'hf2: begin r.kind = k_flt; r.value = 32'h3f800000; end
            8'hf3: begin r.kind = k_flt; r.value = 32'hbf800000; end
            8'hf4: begin r.kind = k_flt; r.value = 32'h40000000; end
            8'hf5: begin r.kind = k_flt; r.value = 32'hc0000000; end
            8'hf6: begin r.kind = k_flt; r.value = 32'h40800000; end
            8'hf7: begin r.kind = k_flt; r.value = 32'hc0800000; end
            8'hf8: begin r.kind = k_flt; r.value = 32'h3e22f983; end
            default: r.kind = k_rsvd;
         endcase
      end
      return r;
   endfunction

   // opcode group; cl_none marks an undefined opcode
   function automatic tovd_cls_t op_cls(input logic [9:0] op);
      tovd_cls_t c;
      c = cl_none;
      if (op < 10'h100) begin
         // compares, mask-updating copies in upper half
         if (op[6:0] inside {[7'h00:7'h2f], [7'h31:7'h36],
                             [7'h39:7'h3e], [7'h40:7'h5f],
                             [7'h7d:7'h7f]})
            c = op[7] ? cl_cmpx : cl_cmp;
      end else if (op inside {[10'h180:10'h188], [10'h18a:10'h19c],
                              [10'h1a0:10'h1a5], 10'h1a7, 10'h1aa,
                              10'h1ab, 10'h1ae, 10'h1af, 10'h1b1,
                              [10'h1b3:10'h1c0], [10'h1c2:10'h1c4],
                              10'h1c8, [10'h1d0:10'h1e4],
                              [10'h1e9:10'h1eb]}) begin
         c = cl_one;
      end else if (op inside {[10'h120:10'h122],
                              [10'h2fc:10'h302]}) begin
         c = cl_sd;
      end else if (op inside {10'h101, [10'h103:10'h10c],
                              [10'h10f:10'h114], [10'h118:10'h11e],
                              [10'h125:10'h127], 10'h12b, 10'h12f,
                              [10'h132:10'h136],
                              [10'h139:10'h13b]}) begin
         c = cl_two;
      end else if (op inside {[10'h209:10'h228], [10'h237:10'h23b],
                              10'h23d, 10'h240, 10'h241,
                              [10'h244:10'h251], [10'h253:10'h267],
                              [10'h303:10'h307], [10'h309:10'h30e],
                              [10'h311:10'h313], [10'h31c:10'h32f],
                              [10'h338:10'h33a], [10'h33c:10'h33e],
                              [10'h360:10'h364]}) begin
         c = cl_nat;
      end
      return c;
   endfunction

   // second and third share the map
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_src
         assign src_dec[g] = dec_src(
            dw_data_i[`TOVD_SRC_W*g +: `TOVD_SRC_W]);
      end
   endgenerate

   // first dword fields, second dword sources
   always_comb begin
      next_inst = '0;
      next_need = 1'b0;
      next_inst.dest     = dw0[`TOVD_DEST_MSB:0];
      next_inst.abs_mask = dw0[`TOVD_ABS_MSB:`TOVD_ABS_LSB];
      next_inst.hsel     = dw0[`TOVD_HSEL_MSB:`TOVD_HSEL_LSB];
      next_inst.clamp    = dw0[`TOVD_CLAMP];
      next_inst.opcode   = dw0[`TOVD_OP_MSB:`TOVD_OP_LSB];
      next_inst.scale    = tovd_scale_t'(
         dw_data_i[`TOVD_OUTPUT_SCALE_MSB:`TOVD_OUTPUT_SCALE_LSB]);
      next_inst.neg_mask = dw_data_i[`TOVD_NEG_MSB:`TOVD_NEG_LSB];
      next_inst.src      = src_dec;
      next_inst.cls      = op_cls(next_inst.opcode);
      // bits 14:8 become the scalar destination
      if (next_inst.cls == cl_sd) begin
         next_inst.sd_variant = 1'b1;
         next_inst.sdst       = dw0[`TOVD_SDST_MSB:`TOVD_SDST_LSB];
         next_inst.abs_mask   = 3'h0;
         next_inst.hsel       = 4'h0;
      end
      if (next_inst.cls == cl_cmp || next_inst.cls == cl_cmpx) begin
         // result lands in the scalar named by dest
         next_inst.scalar_dst = 1'b1;
         next_inst.lane_execution_mask_upd   = next_inst.cls == cl_cmpx;
         // split into family base and offset
         if (next_inst.opcode[6:0] < 7'h30) begin
            next_inst.cmp_offset = next_inst.opcode[3:0];
            next_inst.cmp_base   = {next_inst.opcode[9:4], 4'h0};
         end else if (next_inst.opcode[6:0] >= 7'h7d) begin
            next_inst.cmp_base   = next_inst.opcode;
         end else begin
            next_inst.cmp_offset = {1'b0, next_inst.opcode[2:0]};
            next_inst.cmp_base   = {next_inst.opcode[9:3], 3'h0};
         end
      end
      next_inst.illegal = next_inst.cls == cl_none;
      for (int i = 0; i < 3; i++) begin
         if (src_dec[i].kind == k_rsvd)
            next_inst.illegal = 1'b1;
         // one trailing dword serves all sources
         if (src_dec[i].kind inside {k_lit, k_perm8, k_perm8f, k_perm16})
            next_need = 1'b1;
      end
      next_inst.has_trail = next_need;
   end

   // sequencer of the dword stream
   always_ff @(posedge clk_i) begin
      if (rst_i || flush) begin
         st  <= st_first;
         dw0 <= 32'h0;
      end else if (take) begin
         case (st)
            st_first: begin
               if (enc_ok) begin
                  dw0 <= dw_data_i;
                  st  <= st_second;
               end
            end
            st_second: st <= next_need ? st_trail : st_first;
            st_trail:  st <= st_first;
            default:   st <= st_first;
         endcase
      end
   end

   // fields load with the second dword, valid waits for the last
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inst_o       <= '0;
         inst_valid_o <= 1'b0;
      end else begin
         inst_valid_o <= 1'b0;
         if (take && st == st_second && !flush) begin
            inst_o       <= next_inst;
            inst_valid_o <= !next_need;
         end else if (take && st == st_trail && !flush) begin
            // trailing dword fills every literal source
            inst_o.trail <= dw_data_i;
            for (int i = 0; i < 3; i++)
               if (inst_o.src[i].kind == k_lit)
                  inst_o.src[i].value <= dw_data_i;
            inst_valid_o <= 1'b1;
         end
      end
   end

   // flow control follows the enable bit, one cycle late
   always_ff @(posedge clk_i) begin
      if (rst_i)
         dw_ready_o <= 1'b0;
      else
         dw_ready_o <= ctrl_en;
   end

   // control register
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ctrl_en <= `TOVD_CTRL_RST;
      else if (wb_wr && wb_adr_i == `TOVD_CTRL_ADR)
         ctrl_en <= wb_dat_i[0];
   end

   // sticky status; a new event beats a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         illegal_seen <= 1'b0;
         foreign_seen <= 1'b0;
         inst_cnt     <= 16'h0;
      end else begin
         if (wb_wr && wb_adr_i == `TOVD_STAT_ADR) begin
            if (wb_dat_i[0])
               illegal_seen <= 1'b0;
            if (wb_dat_i[1])
               foreign_seen <= 1'b0;
         end
         if (inst_valid_o && inst_o.illegal)
            illegal_seen <= 1'b1;
         if (take && st == st_first && !enc_ok)
            foreign_seen <= 1'b1;
         if (inst_valid_o)
            inst_cnt <= inst_cnt + 16'h1;
      end
   end

   // bus answer one cycle after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= 32'h0;
         if (wb_req && !wb_ack_o && !wb_we_i) begin
            case (wb_adr_i)
               `TOVD_CTRL_ADR: wb_dat_o <= {31'h0, ctrl_en};
               `TOVD_STAT_ADR: wb_dat_o <= {inst_cnt, 14'h0,
                                            foreign_seen, illegal_seen};
               default:        wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_head;
      st == st_first && take && enc_ok && !flush;
   endsequence
   sequence s_body;
      take && !next_need && !flush;
   endsequence

   op_field_a: assert property (
      s_head ##1 s_body |=> inst_valid_o &&
         inst_o.opcode == $past(dw_op, 2))
      else $error("opcode not taken from first dword");
   dest_field_a: assert property (
      s_head ##1 s_body |=> inst_o.dest == $past(dw_dest, 2))
      else $error("destination index wrong");
   fmt_gate_a: assert property (
      st == st_first && take && !enc_ok |=>
         st == st_first ##1 !inst_valid_o)
      else $error("foreign encoding accepted");
   one_pulse_a: assert property (
      inst_valid_o |=> !inst_valid_o)
      else $error("decode valid held too long");
   scalar_gp_register_map_a: assert property (
      inst_valid_o && inst_o.src[0].sel <= 9'h069 |->
         inst_o.src[0].kind == k_scalar_gp_register &&
         inst_o.src[0].index == inst_o.src[0].sel[7:0])
      else $error("scalar register map wrong");
   vector_gp_register_map_a: assert property (
      inst_valid_o && inst_o.src[2].sel[8] |->
         inst_o.src[2].kind == k_vector_gp_register &&
         inst_o.src[2].index == inst_o.src[2].sel[7:0])
      else $error("vector register map wrong");
   rsvd_code_a: assert property (
      inst_valid_o && inst_o.src[1].sel inside
         {[9'h0d1:9'h0e8], 9'h0ef, 9'h0fe} |->
         inst_o.src[1].kind == k_rsvd && inst_o.illegal)
      else $error("reserved source not flagged");
   trail_word_a: assert property (
      st == st_trail && take && !flush |=>
         inst_valid_o && inst_o.trail == $past(dw_data_i))
      else $error("trailing dword not delivered");
   neg_const_a: assert property (
      inst_valid_o && inst_o.src[0].sel == 9'h0c1 |->
         inst_o.src[0].value == 32'hffffffff)
      else $error("minus one constant wrong");
   lane_execution_mask_cmp_a: assert property (
      inst_valid_o && inst_o.opcode == 10'h082 |->
         inst_o.cls == cl_cmpx && inst_o.lane_execution_mask_upd)
      else $error("mask-updating compare not decoded");
endmodule // tovd_decode

// ==== logic/tovd_params.svh ====
// field positions, register offsets and reset values of the decoder
`ifndef TOVD_PARAMS_SVH
`define TOVD_PARAMS_SVH
`define TOVD_ENC       6'h35
`define TOVD_ENC_MSB   31
`define TOVD_ENC_LSB   26
`define TOVD_OP_MSB    25
`define TOVD_OP_LSB    16
`define TOVD_CLAMP     15
`define TOVD_HSEL_MSB  14
`define TOVD_HSEL_LSB  11
`define TOVD_ABS_MSB   10
`define TOVD_ABS_LSB   8
`define TOVD_SDST_MSB  14
`define TOVD_SDST_LSB  8
`define TOVD_DEST_MSB  7
`define TOVD_SRC_W     9
`define TOVD_OUTPUT_SCALE_MSB  28
`define TOVD_OUTPUT_SCALE_LSB  27
`define TOVD_NEG_MSB   31
`define TOVD_NEG_LSB   29
`define TOVD_CTRL_ADR  8'h00
`define TOVD_STAT_ADR  8'h04
`define TOVD_CTRL_RST  1'h1
`endif

// ==== logic/tovd_pkg.sv ====
// types shared by the three-operand vector decoder
package tovd_pkg;
   typedef enum logic [4:0] {
      k_scalar_gp_register, k_vcclo, k_vcchi, k_trap, k_null, k_misc0, k_execlo,
      k_exechi, k_int, k_flt, k_aper, k_perm8, k_perm8f, k_perm16,
      k_scc, k_lit, k_vector_gp_register, k_rsvd
   } tovd_kind_t;
   typedef enum logic [1:0] {
      sc_none = 2'h0, sc_x2 = 2'h1, sc_x4 = 2'h2, sc_half = 2'h3
   } tovd_scale_t;
   typedef enum logic [2:0] {
      cl_cmp, cl_cmpx, cl_one, cl_two, cl_nat, cl_sd, cl_none
   } tovd_cls_t;
   typedef enum logic [2:0] {
      st_first = 3'h1, st_second = 3'h2, st_trail = 3'h4
   } tovd_state_t;
   typedef struct packed {
      logic [8:0]  sel;
      tovd_kind_t  kind;
      logic [7:0]  index;
      logic [31:0] value;
   } tovd_src_t;
   typedef struct packed {
      logic [7:0]       dest;
      logic [6:0]       sdst;
      logic [2:0]       abs_mask;
      logic [3:0]       hsel;
      logic             clamp;
      logic [9:0]       opcode;
      tovd_scale_t      scale;
      logic [2:0]       neg_mask;
      tovd_cls_t        cls;
      logic [9:0]       cmp_base;
      logic [3:0]       cmp_offset;
      logic             scalar_dst;
      logic             lane_execution_mask_upd;
      logic             sd_variant;
      logic             illegal;
      logic             has_trail;
      logic [31:0]      trail;
      tovd_src_t [2:0]  src;
   } tovd_inst_t;
endpackage : tovd_pkg

// ==== tb/tovd_seq_model.sv ====
// sequencer model that feeds instruction dwords to the decoder
module tovd_seq_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // dword stream
   input  wire logic        dw_ready_i,
   input  wire logic        stall_i,
   output logic             dw_valid_o,
   output logic [31:0]      dw_data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] pend_q[$];
   logic [31:0] last;
   task automatic push(input logic [31:0] d);
      pend_q.push_back(d);
   endtask
   always @(posedge clk_i) begin
      if (rst_i) begin
         dw_valid_o <= 1'b0;
         dw_data_o  <= 32'h0;
         last = 32'h0;
      end else if (!dw_valid_o || dw_ready_i) begin
         if (dw_valid_o)
            void'(pend_q.pop_front());
         if (pend_q.size() > 0 && !stall_i) begin
            dw_valid_o <= 1'b1;
            dw_data_o  <= pend_q[0];
            last = pend_q[0];
         end else begin
            // idle line shows the inverse, so a stale word never matches
            dw_valid_o <= 1'b0;
            dw_data_o  <= ~last;
         end
      end
   end
endmodule // tovd_seq_model

// ==== tb/three_operand_vector_decode_test.sv ====
// self-checking bench for the three-operand vector decoder
module three_operand_vector_decode_test;
   timeunit 1ns;
   timeprecision 1ns;
   import tovd_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        stall = 1'b0;
   logic        dw_valid;
   logic        dw_ready;
   logic [31:0] dw_data;
   logic        inst_valid;
   tovd_inst_t  inst;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h0;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   int          bad_count = 0;
   int          total_checks = 0;
   int          seed = 96;
   tovd_inst_t  exp_q[$];
   logic [9:0]  op_tab[21] = '{10'h0, 10'h2f, 10'h5f, 10'h7f, 10'h80,
      10'hff, 10'h180, 10'h181, 10'h1eb, 10'h101, 10'h13b, 10'h209,
      10'h267, 10'h303, 10'h364, 10'h120, 10'h302, 10'h30, 10'h189,
      10'h3ff, 10'h100};
   tovd_cls_t   cls_tab[21] = '{cl_cmp, cl_cmp, cl_cmp, cl_cmp, cl_cmpx,
      cl_cmpx, cl_one, cl_one, cl_one, cl_two, cl_two, cl_nat, cl_nat,
      cl_nat, cl_nat, cl_sd, cl_sd, cl_none, cl_none, cl_none, cl_none};
   logic [31:0] flt_tab[9] = '{32'h3f000000, 32'hbf000000, 32'h3f800000,
      32'hbf800000, 32'h40000000, 32'hc0000000, 32'h40800000,
      32'hc0800000, 32'h3e22f983};

   always #5 clk_i = ~clk_i;
   // sequencer answers promptly or slowly at random
   always @(posedge clk_i) stall <= ($random(seed) & 3) == 0;

   tovd_seq_model seq_u (.clk_i(clk_i), .rst_i(rst_i), .dw_ready_i(dw_ready),
      .stall_i(stall), .dw_valid_o(dw_valid), .dw_data_o(dw_data));
   tovd_decode dut_u (.clk_i(clk_i), .rst_i(rst_i), .dw_valid_i(dw_valid),
      .dw_data_i(dw_data), .dw_ready_o(dw_ready), .inst_valid_o(inst_valid),
      .inst_o(inst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic tovd_kind_t kind_of(logic [8:0] s);
      case (s) inside
         [0:105]: return k_scalar_gp_register;
         106: return k_vcclo;
         107: return k_vcchi;
         [108:123]: return k_trap;
         124: return k_null;
         125: return k_misc0;
         126: return k_execlo;
         127: return k_exechi;
         [128:208]: return k_int;
         233: return k_perm8;
         234: return k_perm8f;
         [235:238]: return k_aper;
         [240:248]: return k_flt;
         250: return k_perm16;
         253: return k_scc;
         255: return k_lit;
         [256:511]: return k_vector_gp_register;
         default: return k_rsvd;
      endcase
   endfunction

   function automatic tovd_inst_t exp_of(logic [31:0] a, logic [31:0] b,
                                         logic [31:0] t, tovd_cls_t c);
      tovd_inst_t e;
      logic [8:0] s;
      e = '0;
      e.dest = a[7:0];
      e.abs_mask = c == cl_sd ? 3'h0 : a[10:8];
      e.hsel = c == cl_sd ? 4'h0 : a[14:11];
      e.sdst = a[14:8];
      e.clamp = a[15];
      e.opcode = a[25:16];
      e.scale = tovd_scale_t'(b[28:27]);
      e.neg_mask = b[31:29];
      e.cls = c;
      e.lane_execution_mask_upd = c == cl_cmpx;
      e.scalar_dst = c == cl_cmp;
      e.sd_variant = c == cl_sd;
      e.illegal = c == cl_none;
      e.trail = t;
      e.cmp_offset = e.opcode < 10'h30 ? e.opcode[3:0] :
                     e.opcode < 10'h7d ? {1'b0, e.opcode[2:0]} : 4'h0;
      e.cmp_base = e.opcode - 10'(e.cmp_offset);
      for (int i = 0; i < 3; i++) begin
         s = b[9*i +: 9];
         e.src[i].sel = s;
         e.src[i].kind = kind_of(s);
         e.src[i].index = s[7:0] - (s inside {[108:123]} ? 8'h6c :
                                    s inside {[235:238]} ? 8'heb : 8'h0);
         if (s inside {[128:192]})
            e.src[i].value = 32'(s) - 32'h80;
         if (s inside {[193:208]})
            e.src[i].value = 32'hc0 - 32'(s);
         if (s inside {[240:248]})
            e.src[i].value = flt_tab[s - 9'hf0];
         if (s == 9'hff)
            e.src[i].value = t;
         e.has_trail |= s inside {9'he9, 9'hea, 9'hfa, 9'hff};
         e.illegal |= e.src[i].kind == k_rsvd;
      end
      return e;
   endfunction

   // expected decode is noted before the dwords are handed over
   task automatic send(input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] t, input tovd_cls_t c);
      tovd_inst_t e;
      e = exp_of(a, b, t, c);
      exp_q.push_back(e);
      seq_u.push(a);
      seq_u.push(b);
      if (e.has_trail)
         seq_u.push(t);
   endtask

   always @(posedge clk_i) begin
      tovd_inst_t e;
      if (inst_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(1'b1, 1'b0);
         end else begin
            e = exp_q.pop_front();
            check(inst.dest, e.dest);
            check(inst.abs_mask, e.abs_mask);
            check(inst.hsel, e.hsel);
            check(inst.clamp, e.clamp);
            check(inst.opcode, e.opcode);
            check(inst.scale, e.scale);
            check(inst.neg_mask, e.neg_mask);
            check(inst.illegal, e.illegal);
            check(inst.has_trail, e.has_trail);
            check(inst.lane_execution_mask_upd, e.lane_execution_mask_upd);
            check(inst.sd_variant, e.sd_variant);
            if (e.has_trail)
               check(inst.trail, e.trail);
            if (e.cls != cl_none)
               check(inst.cls, e.cls);
            if (e.cls != cl_cmpx)
               check(inst.scalar_dst, e.scalar_dst);
            if (e.sd_variant)
               check(inst.sdst, e.sdst);
            if (e.cls == cl_cmp)
               check({inst.cmp_base, inst.cmp_offset},
                     {e.cmp_base, e.cmp_offset});
            for (int i = 0; i < 3; i++) begin
               check(inst.src[i].sel, e.src[i].sel);
               check(inst.src[i].kind,
                     e.src[i].kind);
               if (e.src[i].kind inside {k_scalar_gp_register, k_trap, k_vector_gp_register, k_aper})
                  check(inst.src[i].index,
                        e.src[i].index);
               if (e.src[i].kind inside {k_int, k_flt, k_lit})
                  check(inst.src[i].value,
                        e.src[i].value);
            end
         end
      end
   end

   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1)
         check(1'b0, 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(q, x);
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 5000) begin
         @(posedge clk_i);
         n++;
      end
      check(exp_q.size(), 0);
      repeat (2) @(posedge clk_i);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      logic [31:0] a;
      logic [31:0] b;
      int k;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(8'h00, 32'h1);
      rd_chk(8'h04, 32'h0);
      wb(1'b1, 8'h08, 32'hffffffff, a);
      rd_chk(8'h08, 32'h0);
      $display("register test done");
      // every source code once as first source, opcodes rotated
      for (int c = 0; c < 512; c++) begin
         k = c % 21;
         a = $random(seed);
         b = $random(seed);
         a[31:16] = {6'h35, op_tab[k]};
         b[8:0] = 9'(c);
         send(a, b, $random(seed), cls_tab[k]);
      end
      drain();
      $display("decode sweep done");
      rd_chk(8'h04, {16'h200, 16'h1});
      wb(1'b1, 8'h04, 32'h3, a);
      rd_chk(8'h04, {16'h200, 16'h0});
      seq_u.push({6'h32, 26'h3ffffff});
      b = {5'h0, 9'h102, 9'h101, 9'h100};
      send({6'h35, 10'h181, 16'h0}, b, 32'h0, cl_one);
      drain();
      rd_chk(8'h04, {16'h201, 16'h2});
      $display("foreign dword test done");
      // a disabled stream holds the sequencer off
      wb(1'b1, 8'h00, 32'h0, a);
      @(posedge clk_i);
      check(dw_ready, 1'b0);
      send({6'h35, 10'h181, 16'h0}, b, 32'h0, cl_one);
      repeat (20) @(posedge clk_i);
      check(exp_q.size(), 1);
      wb(1'b1, 8'h00, 32'h1, a);
      drain();
      rd_chk(8'h04, {16'h202, 16'h2});
      $display("enable test done");
      // a flush drops a half-taken instruction, else the next pairs wrongly
      seq_u.push({6'h35, 10'h181, 16'h0});
      repeat (10) @(posedge clk_i);
      wb(1'b1, 8'h00, 32'h3, a);
      send({6'h35, 10'h181, 16'h0}, b, 32'h0, cl_one);
      drain();
      rd_chk(8'h04, {16'h203, 16'h2});
      $display("flush test done");
      report_and_stop();
   end

   // watchdog well beyond the expected run length
   initial begin
      repeat (30000) @(posedge clk_i);
      check(1'b0, 1'b1);
      report_and_stop();
   end
endmodule // three_operand_vector_decode_test
